// *** irqsw_core.sv ***
// core sequencing model: one instruction per cycle while running
`timescale 1ns/1ps
`default_nettype none
module irqsw_core (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic run,
  input wire logic core_halt_ff,
  input wire logic vec_load_ff,
  input wire logic [12:0] vec_pc_ff,
  output logic instr_done,
  output var logic [12:0] ret_pc
);
  // a halted core completes nothing, so wake-up alone never steps it
  assign instr_done = run & ~core_halt_ff;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ret_pc <= 13'h0000;
    end else if (vec_load_ff) begin
      ret_pc <= vec_pc_ff;
    end else if (instr_done) begin
      ret_pc <= ret_pc + 13'h0001;
    end
  end
endmodule
`default_nettype wire

// *** irqsw_edge.sv ***
// constants package and external pin edge detector for the irq/sleep block
`timescale 1ns/1ps
`default_nettype none

package irqsw_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int PC_W = 13;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_PFLAG = 4'h1;
  localparam logic [3:0] OFS_PEN = 4'h2;
  localparam logic [3:0] OFS_OPT = 4'h3;
  localparam logic [3:0] OFS_POWER_CONTROL_STATUS = 4'h4;
  localparam logic [3:0] OFS_PCLH = 4'h5;
  localparam logic [3:0] OFS_STAT = 4'h6;
  localparam logic [3:0] OFS_MASK = 4'h7;
  localparam logic [3:0] OFS_STATE = 4'h8;
  localparam int CTRL_GIE = 7;
  localparam int CTRL_PEN = 6;
  localparam int CTRL_XEN = 4;
  localparam int CTRL_XFLAG = 1;
  localparam int OPT_EDGE = 6;
  localparam int POWER_CONTROL_STATUS_BOR = 0;
  localparam int EV_EXT = 0;
  localparam int EV_WAKE = 1;
  localparam int EV_VEC = 2;
  localparam int EV_BOR = 3;
  localparam int EV_N = 4;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PFLAG_RST = 8'h00;
  localparam logic [7:0] PEN_RST = 8'h00;
  localparam logic [7:0] OPT_RST = 8'hFF;
  localparam logic [7:0] PCLH_RST = 8'h00;
  localparam logic [3:0] EV_RST = 4'h0;
  // edges after reset before the pin history is trusted
  localparam logic [2:0] EXT_ARM = 3'h4;
  // sources that keep running with the system clock stopped
  localparam logic [7:0] WAKE_CAPABLE = 8'h0F;
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;
  localparam logic [12:0] PC_RST = 13'h0000;
  typedef enum logic [1:0] {st_run, st_sleep, st_after, st_idle} irqsw_st_t;
endpackage

module irqsw_edge (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pin,
  input wire logic rise_sel,
  output logic edge_ff
);
  import irqsw_pkg::*;

  logic meta_ff;
  logic sync_ff;
  logic prev_ff;

  // meta_ff feeds sync_ff only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      meta_ff <= pin;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      edge_ff <= 1'b0;
    end else begin
      edge_ff <= rise_sel ? (sync_ff & ~prev_ff) : (~sync_ff & prev_ff); // [R7]
    end
  end
endmodule

`default_nettype wire

// *** irqsw_top.sv ***
// interrupt entry, sleep wake-up and external pin interrupt logic
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// R1 - only clock-independent peripheral sources may wake the core from sleep
// R2 - a source wakes only if its enable was set before sleep entry
// R3 - wake-up with global enable set leads to the interrupt vector
// R4 - wake-up with global enable clear resumes after the sleep instruction
// R5 - the instruction after sleep always runs before any vectoring
// R6 - external pin is edge triggered and caught without software polling
// R7 - edge select high picks rising edge, low picks falling edge
// R8 - a selected pin edge sets the external interrupt flag
// R9 - flag with global and external enables set forces vector entry
// R10 - external enable clear blocks the pin interrupt from vectoring
// R11 - vector entry pushes only the return program counter
// R12 - vector entry loads the program counter with the fixed vector
// R13 - vector entry leaves the program counter high latch untouched
// R14 - wake-up by interrupt always leaves a flag set in the flag registers
// R15 - brown-out clears power status bit 0, other resets keep it (power-on reset also clears it to 0 here)
// R16 - external flag stays set until software clears it
// R17 - vector entry clears global enable, return sets it and pops stack
module irqsw_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic por_b,
  input wire logic bor_det,
  input wire logic ext_pin,
  input wire logic [7:0] periph_evt,
  input wire logic sleep_exec,
  input wire logic instr_done,
  input wire logic ret_exec,
  input wire logic [irqsw_pkg::PC_W-1:0] ret_pc,
  input wire logic [irqsw_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [irqsw_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [irqsw_pkg::DATA_W-1:0] reg_rdata_ff,
  output logic core_halt_ff,
  output logic vec_load_ff,
  output logic [irqsw_pkg::PC_W-1:0] vec_pc_ff,
  output logic stack_push_ff,
  output logic [irqsw_pkg::PC_W-1:0] push_pc_ff,
  output logic stack_pop_ff,
  output logic [irqsw_pkg::DATA_W-1:0] pc_high_latch_ff,
  output logic irq_out_ff
);
  import irqsw_pkg::*;

  irqsw_st_t state_ff;
  logic [7:0] ctrl_ff;
  logic [7:0] pflag_ff;
  logic [7:0] pen_ff;
  logic [7:0] opt_ff;
  logic [7:0] pen_snap_ff;
  logic xen_snap_ff;
  logic power_control_status_bor_ff;
  logic bor_meta_ff;
  logic bor_sync_ff;
  logic bor_prev_ff;
  logic [EV_N-1:0] stat_ff;
  logic [EV_N-1:0] mask_ff;
  logic ext_edge;
  logic ext_hit;
  logic [2:0] ext_arm_ff;
  logic [7:0] evt_gated;
  logic ext_pend;
  logic per_pend;
  logic pending;
  logic wake;
  logic take;
  logic wr_ctrl;
  logic wr_pflag;
  logic [EV_N-1:0] ev_set;
  logic [7:0] nxt_ctrl;
  logic [7:0] nxt_pflag;
  logic [7:0] nxt_rdata;

  assign wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
  assign wr_pflag = reg_wr && (reg_addr == OFS_PFLAG);

  // pin runs through a two-stage synchroniser; clock is never gated here
  irqsw_edge u_ext_edge (
    .clk(clk),
    .rst_b(rst_b),
    .pin(ext_pin),
    .rise_sel(opt_ff[OPT_EDGE]),
    .edge_ff(ext_edge)
  ); // [R6]

  // the synchroniser holds reset values, not the pin, for its first edges;
  // an idle-high pin would otherwise look like a rising edge after reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_arm_ff <= 3'h0;
    end else if (ext_arm_ff != EXT_ARM) begin
      ext_arm_ff <= ext_arm_ff + 3'h1;
    end
  end

  assign ext_hit = ext_edge && (ext_arm_ff == EXT_ARM); // [R6]

  // a clocked peripheral is frozen while the core sleeps
  assign evt_gated = (state_ff == st_sleep) ?
                     (periph_evt & WAKE_CAPABLE) : periph_evt; // [R1]

  assign ext_pend = ctrl_ff[CTRL_XFLAG] & ctrl_ff[CTRL_XEN]; // [R10]
  assign per_pend = ctrl_ff[CTRL_PEN] & (|(pflag_ff & pen_ff));
  assign pending = ctrl_ff[CTRL_GIE] & (ext_pend | per_pend); // [R9]

  // wake uses enables latched at sleep entry, not the live ones
  assign wake = (state_ff == st_sleep) &&
                ((ctrl_ff[CTRL_XFLAG] & xen_snap_ff) |
                 (|(pflag_ff & pen_snap_ff))); // [R2] [R14]

  // entry only at an instruction boundary
  assign take = instr_done && pending &&
                ((state_ff == st_after) ||
                 (state_ff == st_run && !sleep_exec)); // [R5]

  // ---------------- sequencing ----------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= st_run;
      core_halt_ff <= 1'b0;
    end else begin
      case (state_ff)
        st_run: begin
          // a sleep wins over entry in the same cycle; take is held off by sleep_exec
          if (sleep_exec && !take) begin
            state_ff <= st_sleep;
            core_halt_ff <= 1'b1;
          end
        end
        st_sleep: begin
          if (wake) begin
            core_halt_ff <= 1'b0;
            // one more instruction runs in either case
            state_ff <= ctrl_ff[CTRL_GIE] ? st_after : st_run; // [R3] [R4]
          end
        end
        st_after: begin
          if (sleep_exec && !take) begin
            // a sleep right after wake-up is kept unless entry is taken in the same cycle
            state_ff <= st_sleep;
            core_halt_ff <= 1'b1;
          end else if (instr_done) begin
            state_ff <= st_run;
          end
        end
        default: begin
          state_ff <= st_run;
          core_halt_ff <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pen_snap_ff <= PEN_RST;
      xen_snap_ff <= 1'b0;
    end else if (sleep_exec &&
                 (state_ff == st_run || state_ff == st_after)) begin
      pen_snap_ff <= ctrl_ff[CTRL_PEN] ? pen_ff : PEN_RST;
      xen_snap_ff <= ctrl_ff[CTRL_XEN]; // [R2]
    end
  end

  // ---------------- vector entry and return ----------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vec_load_ff <= 1'b0;
      vec_pc_ff <= PC_RST;
      stack_push_ff <= 1'b0;
      push_pc_ff <= PC_RST;
    end else begin
      vec_load_ff <= take;
      stack_push_ff <= take; // [R11]
      if (take) begin
        vec_pc_ff <= IRQ_VECTOR; // [R12]
        push_pc_ff <= ret_pc; // [R11]
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stack_pop_ff <= 1'b0;
    end else begin
      stack_pop_ff <= ret_exec && !take; // [R17]
    end
  end

  // ---------------- control register ----------------
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_ctrl) begin
      nxt_ctrl = reg_wdata;
    end
    if (ret_exec) begin
      nxt_ctrl[CTRL_GIE] = 1'b1; // [R17]
    end
    if (take) begin
      nxt_ctrl[CTRL_GIE] = 1'b0; // [R17]
    end
    // a pin edge beats a software clear in the same cycle
    if (ext_hit) begin
      nxt_ctrl[CTRL_XFLAG] = 1'b1; // [R8] [R16]
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff <= CTRL_RST;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  always_comb begin
    nxt_pflag = wr_pflag ? reg_wdata : pflag_ff;
    // an event beats a software write of the same bit
    nxt_pflag = nxt_pflag | evt_gated; // [R14]
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pflag_ff <= PFLAG_RST;
    end else begin
      pflag_ff <= nxt_pflag;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pen_ff <= PEN_RST;
      opt_ff <= OPT_RST;
      pc_high_latch_ff <= PCLH_RST;
      mask_ff <= EV_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        OFS_PEN: pen_ff <= reg_wdata;
        OFS_OPT: opt_ff <= reg_wdata; // [R7]
        // vector entry never touches this latch
        OFS_PCLH: pc_high_latch_ff <= reg_wdata; // [R13]
        OFS_MASK: mask_ff <= reg_wdata[EV_N-1:0];
        default: begin
        end
      endcase
    end
  end

  // ---------------- power status ----------------
  // kept on the power-on reset only, so rst_b leaves it alone; brown-out or a software write of 0 clears it
  always_ff @(posedge clk or negedge por_b) begin
    if (!por_b) begin
      bor_meta_ff <= 1'b0;
      bor_sync_ff <= 1'b0;
      bor_prev_ff <= 1'b0;
    end else begin
      bor_meta_ff <= bor_det;
      bor_sync_ff <= bor_meta_ff;
      bor_prev_ff <= bor_sync_ff;
    end
  end

  always_ff @(posedge clk or negedge por_b) begin
    if (!por_b) begin
      power_control_status_bor_ff <= 1'b0;
    end else if (bor_sync_ff) begin
      // clear beats a software write in the same cycle
      power_control_status_bor_ff <= 1'b0; // [R15]
    end else if (reg_wr && reg_addr == OFS_POWER_CONTROL_STATUS) begin
      power_control_status_bor_ff <= reg_wdata[POWER_CONTROL_STATUS_BOR];
    end
  end

  // ---------------- event status and interrupt line ----------------
  always_comb begin
    ev_set = '0;
    ev_set[EV_EXT] = ext_hit;
    ev_set[EV_WAKE] = wake;
    ev_set[EV_VEC] = take;
    ev_set[EV_BOR] = bor_sync_ff & ~bor_prev_ff;
  end

  // a hardware set beats a write-one-to-clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < EV_N; gi = gi + 1) begin : g_stat
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          stat_ff[gi] <= 1'b0;
        end else if (ev_set[gi]) begin
          stat_ff[gi] <= 1'b1;
        end else if (reg_wr && reg_addr == OFS_STAT && reg_wdata[gi]) begin
          stat_ff[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_out_ff <= 1'b0;
    end else begin
      irq_out_ff <= |(stat_ff & mask_ff);
    end
  end

  // ---------------- read port ----------------
  always_comb begin
    nxt_rdata = 8'h00;
    case (reg_addr)
      OFS_CTRL: nxt_rdata = ctrl_ff;
      OFS_PFLAG: nxt_rdata = pflag_ff;
      OFS_PEN: nxt_rdata = pen_ff;
      OFS_OPT: nxt_rdata = opt_ff;
      OFS_POWER_CONTROL_STATUS: nxt_rdata = {7'h00, power_control_status_bor_ff};
      OFS_PCLH: nxt_rdata = pc_high_latch_ff;
      OFS_STAT: nxt_rdata = {4'h0, stat_ff};
      OFS_MASK: nxt_rdata = {4'h0, mask_ff};
      OFS_STATE: nxt_rdata = {5'h00, core_halt_ff, state_ff};
      default: nxt_rdata = 8'h00;
    endcase
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_ff <= nxt_rdata;
    end else begin
      reg_rdata_ff <= 8'h00;
    end
  end
endmodule

`default_nettype wire

// *** irqsw_top_sva.sv ***
// checker for interrupt entry and sleep wake-up behaviour
`timescale 1ns/1ps
`default_nettype none
module irqsw_chk
  import irqsw_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic instr_done,
  input wire logic ret_exec,
  input wire logic sleep_exec,
  input wire logic reg_wr,
  input wire logic [PC_W-1:0] ret_pc,
  input wire logic core_halt_ff,
  input wire logic vec_load_ff,
  input wire logic [PC_W-1:0] vec_pc_ff,
  input wire logic stack_push_ff,
  input wire logic [PC_W-1:0] push_pc_ff,
  input wire logic stack_pop_ff,
  input wire logic [DATA_W-1:0] pc_high_latch_ff
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  property p_vec_addr; vec_load_ff |-> vec_pc_ff == IRQ_VECTOR; endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("bad vector");
  property p_push_pair; vec_load_ff == stack_push_ff; endproperty
  a_push_pair: assert property (p_push_pair) else $error("push split");
  property p_push_pc; stack_push_ff |-> push_pc_ff == $past(ret_pc); endproperty
  a_push_pc: assert property (p_push_pc) else $error("bad push pc");
  property p_on_done; vec_load_ff |-> $past(instr_done); endproperty
  a_on_done: assert property (p_on_done) else $error("early entry");
  property p_one_entry; vec_load_ff |=> !vec_load_ff [*2]; endproperty
  a_one_entry: assert property (p_one_entry) else $error("nested");
  property p_pclh;
    vec_load_ff && !$past(reg_wr) |-> $stable(pc_high_latch_ff);
  endproperty
  a_pclh: assert property (p_pclh) else $error("latch moved");
  property p_pop; stack_pop_ff |-> $past(ret_exec); endproperty
  a_pop: assert property (p_pop) else $error("stray pop");
  property p_halt_rise; $rose(core_halt_ff) |-> $past(sleep_exec); endproperty
  a_halt_rise: assert property (p_halt_rise) else $error("stray halt");
  property p_halt_novec; core_halt_ff |-> !vec_load_ff; endproperty
  a_halt_novec: assert property (p_halt_novec) else $error("vec asleep");
endmodule
bind irqsw_top irqsw_chk chk_u (.clk(clk), .rst_b(rst_b),
  .instr_done(instr_done), .ret_exec(ret_exec), .sleep_exec(sleep_exec),
  .reg_wr(reg_wr), .ret_pc(ret_pc), .core_halt_ff(core_halt_ff),
  .vec_load_ff(vec_load_ff), .vec_pc_ff(vec_pc_ff),
  .stack_push_ff(stack_push_ff), .push_pc_ff(push_pc_ff),
  .stack_pop_ff(stack_pop_ff), .pc_high_latch_ff(pc_high_latch_ff));
`default_nettype wire

// *** tb.sv ***
// self-checking bench for interrupt entry and sleep wake-up
`timescale 1ns/1ps
`default_nettype none
module tb;
  import irqsw_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic por_b = 1'b0;
  logic bor_det = 1'b0;
  logic ext_pin = 1'b0;
  logic [7:0] periph_evt = 8'h00;
  logic sleep_exec = 1'b0;
  logic ret_exec = 1'b0;
  logic run = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic instr_done;
  logic [12:0] ret_pc;
  logic [12:0] vpc;
  logic [7:0] rdata;
  logic [7:0] pclh;
  logic halt;
  logic vec;
  logic pop;
  logic push;
  logic [12:0] ppc;
  logic irq;
  int n_mismatch = 0;
  int n_tests = 0;
  int n_vec = 0;
  int n_push = 0;
  always #20 clk = ~clk;
  irqsw_top dut_u (.clk(clk), .rst_b(rst_b), .por_b(por_b),
    .bor_det(bor_det), .ext_pin(ext_pin), .periph_evt(periph_evt),
    .sleep_exec(sleep_exec), .instr_done(instr_done), .ret_exec(ret_exec),
    .ret_pc(ret_pc), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(rdata),
    .core_halt_ff(halt), .vec_load_ff(vec), .vec_pc_ff(vpc),
    .stack_push_ff(push), .push_pc_ff(ppc), .stack_pop_ff(pop),
    .pc_high_latch_ff(pclh), .irq_out_ff(irq));
  irqsw_core core_u (.clk(clk), .rst_b(rst_b), .run(run),
    .core_halt_ff(halt), .vec_load_ff(vec), .vec_pc_ff(vpc),
    .instr_done(instr_done), .ret_pc(ret_pc));
  always @(posedge clk) begin
    if (vec === 1'b1) n_vec++;
    if (push === 1'b1) n_push++;
  end
  task automatic results;
    if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk({5'h00, rdata}, {5'h00, exp});
  endtask
  task automatic nap;
    @(posedge clk);
    sleep_exec <= 1'b1;
    @(posedge clk);
    sleep_exec <= 1'b0;
    @(negedge clk);
  endtask
  // synchroniser plus edge compare needs about four cycles
  task automatic pin(input logic v);
    @(posedge clk);
    ext_pin <= v;
    repeat (8) @(negedge clk);
  endtask
  task automatic ev(input logic [7:0] v);
    @(posedge clk);
    periph_evt <= v;
    @(posedge clk);
    periph_evt <= 8'h00;
    repeat (4) @(negedge clk);
  endtask
  task automatic step(input int n);
    @(posedge clk);
    run <= 1'b1;
    repeat (n) @(posedge clk);
    run <= 1'b0;
    repeat (2) @(negedge clk);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    por_b <= 1'b1;
    rd(OFS_CTRL, CTRL_RST);
    rd(OFS_OPT, OPT_RST);
    rd(4'hF, 8'h00);
    pin(1'b1);
    rd(OFS_CTRL, 8'h02);
    pin(1'b0);
    rd(OFS_CTRL, 8'h02);
    wr(OFS_CTRL, 8'h00);
    wr(OFS_OPT, 8'hBF);
    pin(1'b1);
    rd(OFS_CTRL, 8'h00);
    pin(1'b0);
    rd(OFS_CTRL, 8'h02);
    wr(OFS_MASK, 8'h01);
    repeat (2) @(negedge clk);
    chk({12'h000, irq}, 13'h0001);
    wr(OFS_MASK, 8'h00);
    repeat (2) @(negedge clk);
    chk({12'h000, irq}, 13'h0000);
    wr(OFS_MASK, 8'h01);
    wr(OFS_STAT, 8'h0F);
    repeat (2) @(negedge clk);
    chk({12'h000, irq}, 13'h0000);
    wr(OFS_PCLH, 8'h5A);
    wr(OFS_CTRL, 8'h92);
    step(4);
    chk(13'(n_vec), 13'h0001);
    chk(13'(n_push), 13'h0001);
    chk(vpc, IRQ_VECTOR);
    chk({5'h00, pclh}, 13'h005A);
    rd(OFS_CTRL, 8'h12);
    @(posedge clk);
    ret_exec <= 1'b1;
    @(posedge clk);
    ret_exec <= 1'b0;
    @(negedge clk);
    chk({12'h000, pop}, 13'h0001);
    rd(OFS_CTRL, 8'h92);
    wr(OFS_CTRL, 8'h82);
    step(10);
    chk(13'(n_vec), 13'h0001);
    wr(OFS_CTRL, 8'h10);
    nap;
    chk({12'h000, halt}, 13'h0001);
    pin(1'b1);
    pin(1'b0);
    chk({12'h000, halt}, 13'h0000);
    rd(OFS_CTRL, 8'h12);
    step(4);
    chk(13'(n_vec), 13'h0001);
    wr(OFS_CTRL, 8'h90);
    nap;
    pin(1'b1);
    pin(1'b0);
    chk({12'h000, halt}, 13'h0000);
    chk(13'(n_vec), 13'h0001);
    step(4);
    chk(13'(n_vec), 13'h0002);
    chk(13'(n_push), 13'h0002);
    chk(ppc, 13'h0014);
    rd(OFS_STAT, 8'h07);
    wr(OFS_PEN, 8'hFF);
    wr(OFS_CTRL, 8'h40);
    nap;
    ev(8'h10);
    chk({12'h000, halt}, 13'h0001);
    ev(8'h01);
    chk({12'h000, halt}, 13'h0000);
    rd(OFS_PFLAG, 8'h01);
    wr(OFS_PFLAG, 8'h00);
    wr(OFS_PEN, 8'h00);
    nap;
    wr(OFS_PEN, 8'hFF);
    ev(8'h01);
    chk({12'h000, halt}, 13'h0001);
    rd(OFS_STATE, 8'h05);
    wr(OFS_POWER_CONTROL_STATUS, 8'h01);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(OFS_POWER_CONTROL_STATUS, 8'h01);
    @(posedge clk);
    bor_det <= 1'b1;
    repeat (4) @(posedge clk);
    bor_det <= 1'b0;
    rd(OFS_POWER_CONTROL_STATUS, 8'h00);
    rd(OFS_STAT, 8'h08);
    results;
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    results;
  end
endmodule
`default_nettype wire
